// File: ccc_core.sv
// coulomb counter core: accumulators, duration timers, self-discharge, sleep
// assumes converter strobes and register port are on sys_clk_i; host line is a pin
//
// Functional notes
// - discharge strobe adds one to the discharge accumulator
// - discharge duration counter advances once per duration tick while discharging
// - charge strobe adds one to the charge accumulator
// - charge duration counter advances once per duration tick while charging
// - only the accumulator matching sense polarity may count
// - duration counters are 16 bits and wrap past ffff
// - wrap sets the slow flag; then one count per 256 ticks
// - self-discharge rate one per hour at 25 C, doubling per 10 C up to 60 C
// - self-discharge rate halves per 10 C below 25 C, floor 0 C
// - offset pulses cancel counts automatically, no host calibration
// - after sleep command and low activity, stop all but self-discharge
// - 3-bit wake field picks the sleep threshold, 0 means none, reset 7
// - asleep, wake briefly for each self-discharge update
// - any host line edge ends sleep
// - writing one to a clear bit zeroes that counter
// - clear bit returns to zero by itself when done
// - clearing a duration counter also drops its slow flag; a wrap in the same cycle sets it instead
// - regulator disable bit turns the regulator off
// - status pin follows the level the host sets
// - die temperature in kelvin on a two-byte register pair
// - command f6 at 62 requests sleep
// - command 45 copies ram page 0 into flash page 0
`timescale 1ns/100ps
module ccc_core import ccc_pkg::*; #(
  parameter int unsigned DUR_TICK = DUR_TICK_CYCLES,
  parameter int unsigned SD_TICK = SD_BASE_TICK_CYCLES,
  parameter int unsigned SLOW_RATIO = SLOW_DIV
) (
  // clock, reset, enable
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic clk_en_i,
  // voltage-to-frequency converter
  input wire logic chg_pulse_i,
  input wire logic dsg_pulse_i,
  input wire logic chg_active_i,
  input wire logic dsg_active_i,
  input wire logic offset_pulse_i,
  input wire logic [11:0] activity_uv_i,
  // temperature sensor, kelvin
  input wire logic [8:0] temp_k_i,
  // single-wire host line, raw pin level
  input wire logic host_line_i,
  // register port from the link engine
  input wire ccc_reg_req_t reg_req_i,
  output logic [7:0] reg_rdata_o,
  // pins and system controls
  output logic stat_o,
  output logic stat_oe_o,
  output logic regulator_en_o,
  output logic sleep_o,
  output logic flash_copy_o
);

  // ****************************************
  // state
  // ****************************************
  ccc_state_t state;
  ccc_state_t next_state;
  logic [15:0] discharge_charge_accumulator;
  logic [15:0] charge_accumulator;
  logic [15:0] self_discharge_accumulator;
  logic [15:0] dur [2];
  logic [7:0] pre [2];
  logic [1:0] slow;
  logic [4:0] clr_pend;
  logic stat_lvl;
  logic [2:0] wake_code;
  logic reg_dis;
  logic [3:0] cancel_pend;
  logic [10:0] sd_acc;
  logic [8:0] temp_q;
  logic h1;
  logic h2;
  logic h3;
  logic host_lvl;

  // ****************************************
  // register decode
  // ****************************************
  wire logic wr_cmd = reg_req_i.wr && (reg_req_i.addr == ADDR_CMD);
  wire logic wr_clr = reg_req_i.wr && (reg_req_i.addr == ADDR_CLR);
  wire logic wr_mode = reg_req_i.wr && (reg_req_i.addr == ADDR_MODE);
  wire logic sleep_cmd = wr_cmd && (reg_req_i.wdata == CMD_SLEEP);
  wire logic copy_cmd = wr_cmd && (reg_req_i.wdata == CMD_RAM_TO_FLASH);
  wire logic [7:0] mode_rd = {1'b0, reg_dis, slow[1], slow[0], wake_code, 1'b0};
  wire logic [7:0] clr_rd = {2'b00, stat_lvl, clr_pend};
  wire logic [7:0] next_rdata =
    (reg_req_i.addr == ADDR_TEMP_LO) ? temp_q[7:0] :
    (reg_req_i.addr == ADDR_TEMP_HI) ? {7'h00, temp_q[8]} :
    (reg_req_i.addr == ADDR_CLR) ? clr_rd :
    (reg_req_i.addr == ADDR_MODE) ? mode_rd :
    (reg_req_i.addr == ADDR_CTC_LO) ? dur[1][7:0] :
    (reg_req_i.addr == ADDR_CTC_HI) ? dur[1][15:8] :
    (reg_req_i.addr == ADDR_DTC_LO) ? dur[0][7:0] :
    (reg_req_i.addr == ADDR_DTC_HI) ? dur[0][15:8] :
    (reg_req_i.addr == ADDR_SCR_LO) ? self_discharge_accumulator[7:0] :
    (reg_req_i.addr == ADDR_SCR_HI) ? self_discharge_accumulator[15:8] :
    (reg_req_i.addr == ADDR_CCR_LO) ? charge_accumulator[7:0] :
    (reg_req_i.addr == ADDR_CCR_HI) ? charge_accumulator[15:8] :
    (reg_req_i.addr == ADDR_DCR_LO) ? discharge_charge_accumulator[7:0] :
    (reg_req_i.addr == ADDR_DCR_HI) ? discharge_charge_accumulator[15:8] : 8'h00;

  // ****************************************
  // host line synchroniser and edge
  // ****************************************
  // a change counts only when the second and third stages agree
  wire logic host_edge = (h2 == h3) && (h3 != host_lvl);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      h1 <= 1'b1;
      h2 <= 1'b1;
      h3 <= 1'b1;
      host_lvl <= 1'b1;
    end else if (clk_en_i) begin
      h1 <= host_line_i;
      h2 <= h1;
      h3 <= h2;
      if (h2 == h3) begin
        host_lvl <= h3;
      end
    end
  end

  // ****************************************
  // acquisition and offset cancel
  // ****************************************
  wire logic acq = (state == ST_RUN) || (state == ST_DRAIN);
  // polarity selects which accumulator may count
  wire logic chg_sel = chg_active_i && !dsg_active_i;
  wire logic dsg_sel = dsg_active_i && !chg_active_i;
  wire logic raw_cnt = acq && ((chg_pulse_i && chg_sel) || (dsg_pulse_i && dsg_sel));
  // pending offset counts swallow the next real strobes
  wire logic swallow = (cancel_pend != 4'h0);
  wire logic chg_cnt = acq && chg_pulse_i && chg_sel && !swallow;
  wire logic dsg_cnt = acq && dsg_pulse_i && dsg_sel && !swallow;
  wire logic cancel_inc = offset_pulse_i && (cancel_pend != 4'hF);
  wire logic cancel_dec = raw_cnt && swallow;

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cancel_pend <= 4'h0;
    end else if (clk_en_i) begin
      if (cancel_inc && !cancel_dec) begin
        cancel_pend <= cancel_pend + 4'h1;
      end else if (cancel_dec && !cancel_inc) begin
        cancel_pend <= cancel_pend - 4'h1;
      end
    end
  end

  // ****************************************
  // charge and discharge accumulators
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      discharge_charge_accumulator <= 16'h0000;
      charge_accumulator <= 16'h0000;
    end else if (clk_en_i) begin
      if (clr_pend[CLR_DCR_BIT]) begin
        discharge_charge_accumulator <= 16'h0000;
      end else if (dsg_cnt) begin
        discharge_charge_accumulator <= discharge_charge_accumulator + 16'h0001;
      end
      if (clr_pend[CLR_CCR_BIT]) begin
        charge_accumulator <= 16'h0000;
      end else if (chg_cnt) begin
        charge_accumulator <= charge_accumulator + 16'h0001;
      end
    end
  end

  // ****************************************
  // duration counters, index 0 discharge, 1 charge
  // ****************************************
  logic dur_tick;
  logic sd_tick;
  ccc_tick_div #(.PERIOD(DUR_TICK)) u_dur_div (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .ce_i(clk_en_i),
    .run_i(acq),
    .tick_o(dur_tick)
  );

  wire logic [1:0] dur_act = {chg_sel, dsg_sel};
  wire logic [1:0] dur_clr = {clr_pend[CLR_CTC_BIT], clr_pend[CLR_DTC_BIT]};
  logic [1:0] dur_step;
  logic [1:0] roll;

  for (genvar i = 0; i < 2; i++) begin : g_dur
    // slow mode steps once per full prescaler cycle
    assign dur_step[i] = acq && dur_tick && dur_act[i] &&
      (!slow[i] || (pre[i] == 8'(SLOW_RATIO - 1)));
    assign roll[i] = dur_step[i] && (dur[i] == 16'hFFFF);

    always_ff @(posedge sys_clk_i) begin
      if (srst_i) begin
        dur[i] <= 16'h0000;
        pre[i] <= 8'h00;
        slow[i] <= 1'b0;
      end else if (clk_en_i) begin
        // one count per tick while active, one per full prescaler cycle when slow
        if (dur_clr[i]) begin
          dur[i] <= 16'h0000;
        end else if (dur_step[i]) begin
          dur[i] <= dur[i] + 16'h0001;
        end
        if (dur_clr[i]) begin
          pre[i] <= 8'h00;
        end else if (acq && dur_tick && dur_act[i] && slow[i]) begin
          pre[i] <= pre[i] + 8'h01;
        end
        // clear drops the flag; a wrap in the same cycle wins
        if (roll[i]) begin
          slow[i] <= 1'b1;
        end else if (dur_clr[i]) begin
          slow[i] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // self-discharge counter
  // ****************************************
  // always-on timer; in sleep it only triggers a brief wake
  ccc_tick_div #(.PERIOD(SD_TICK)) u_sd_div (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .ce_i(clk_en_i),
    .run_i(1'b1),
    .tick_o(sd_tick)
  );

  wire logic [9:0] temp_c = {1'b0, temp_q} - KELVIN_AT_0C;
  wire logic below_0c = temp_c[9];
  wire logic [9:0] band_raw = temp_c / SD_BAND_STEP_C;
  // weight doubles per 10 C band, clamped at 0 C and 60 C
  wire logic [2:0] band = below_0c ? 3'h0 :
    (band_raw >= {7'h00, SD_TOP_BAND}) ? SD_TOP_BAND : band_raw[2:0];
  wire logic [10:0] sd_weight = 11'h001 << band;
  wire logic [10:0] sd_sum = sd_acc + sd_weight;
  // in sleep the update happens in the brief wake state
  wire logic sd_add = (sd_tick && (state != ST_SLEEP)) || (state == ST_SDWAKE);

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      self_discharge_accumulator <= 16'h0000;
      sd_acc <= 11'h000;
    end else if (clk_en_i) begin
      if (clr_pend[CLR_SCR_BIT]) begin
        self_discharge_accumulator <= 16'h0000;
        sd_acc <= 11'h000;
      end else if (sd_add) begin
        if (sd_sum >= SD_COUNT_SUM) begin
          self_discharge_accumulator <= self_discharge_accumulator + 16'h0001;
          sd_acc <= sd_sum - SD_COUNT_SUM;
        end else begin
          sd_acc <= sd_sum;
        end
      end
    end
  end

  // ****************************************
  // sleep control
  // ****************************************
  // code 0 has no threshold, sleep is taken at once
  wire logic below_wake = (wake_code == 3'h0) || (activity_uv_i < WAKE_UV[wake_code]);

  always_comb begin
    next_state = state;
    case (state)
      ST_RUN: begin
        // host is trusted to have saved the ram page first
        if (sleep_cmd) begin
          next_state = ST_DRAIN;
        end
      end
      ST_DRAIN: begin
        // wait for activity to fall below the threshold
        if (host_edge) begin
          next_state = ST_RUN;
        end else if (below_wake) begin
          next_state = ST_SLEEP;
        end
      end
      ST_SLEEP: begin
        // any settled edge on the host line wakes
        if (host_edge) begin
          next_state = ST_RUN;
        end else if (sd_tick) begin
          next_state = ST_SDWAKE;
        end
      end
      ST_SDWAKE: begin
        next_state = host_edge ? ST_RUN : ST_SLEEP;
      end
      default: begin
        next_state = ST_RUN;
      end
    endcase
  end

  // ****************************************
  // control registers and outputs
  // ****************************************
  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      state <= ST_RUN;
      clr_pend <= 5'h00;
      stat_lvl <= STAT_RESET;
      wake_code <= WAKE_RESET;
      reg_dis <= 1'b0;
      temp_q <= 9'h000;
      reg_rdata_o <= 8'h00;
      stat_o <= STAT_RESET;
      stat_oe_o <= !STAT_RESET;
      regulator_en_o <= 1'b1;
      sleep_o <= 1'b0;
      flash_copy_o <= 1'b0;
    end else if (clk_en_i) begin
      state <= next_state;
      // pending clears last one cycle, then read back zero
      clr_pend <= wr_clr ? reg_req_i.wdata[4:0] : 5'h00;
      if (wr_clr) begin
        stat_lvl <= reg_req_i.wdata[CLR_STAT_BIT];
      end
      if (wr_mode) begin
        wake_code <= reg_req_i.wdata[MODE_WAKE_LSB +: 3];
        reg_dis <= reg_req_i.wdata[MODE_REGDIS_BIT];
      end
      // kelvin reading held for the register pair
      if (acq) begin
        temp_q <= temp_k_i;
      end
      reg_rdata_o <= reg_req_i.rd ? next_rdata : reg_rdata_o;
      // open-drain status pin pulls low for a zero
      stat_o <= stat_lvl;
      stat_oe_o <= !stat_lvl;
      // regulator stays on in sleep unless disabled
      regulator_en_o <= !reg_dis;
      sleep_o <= (next_state == ST_SLEEP);
      flash_copy_o <= copy_cmd && (state == ST_RUN);
    end
  end

  // ****************************************
  // checks
  // ****************************************
  chk_dcr_step: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    clk_en_i && dsg_cnt && !clr_pend[CLR_DCR_BIT] |=> discharge_charge_accumulator == $past(discharge_charge_accumulator) + 16'h0001)
    else $error("discharge accumulator missed a strobe");
  chk_ccr_step: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    clk_en_i && chg_cnt && !clr_pend[CLR_CCR_BIT] |=> charge_accumulator == $past(charge_accumulator) + 16'h0001)
    else $error("charge accumulator missed a strobe");
  chk_one_acc: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    clk_en_i && (clr_pend == 5'h00) |=> !($changed(charge_accumulator) && $changed(discharge_charge_accumulator)))
    else $error("both accumulators moved together");
  chk_roll_slow: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    clk_en_i && roll[0] |=> slow[0] && (dur[0] == 16'h0000))
    else $error("wrap did not set the slow flag");
  chk_clr_done: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    clk_en_i && clr_pend[CLR_CTC_BIT] && !roll[1] |=>
      !slow[1] && (dur[1] == 16'h0000) && !clr_pend[CLR_CTC_BIT])
    else $error("charge duration clear incomplete");
  chk_sleep_cmd: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    clk_en_i && sleep_cmd && (state == ST_RUN) |=> state == ST_DRAIN)
    else $error("sleep command not taken");
  chk_sleep_entry: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    clk_en_i && (state == ST_DRAIN) && below_wake && !host_edge |=> sleep_o)
    else $error("sleep not entered below threshold");
  chk_wake_edge: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    clk_en_i && (state == ST_SLEEP) && host_edge |=> !sleep_o && (state == ST_RUN))
    else $error("host edge did not wake");
  chk_sleep_hold: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (state == ST_SLEEP) && !clr_pend[CLR_SCR_BIT] |=> $stable(self_discharge_accumulator))
    else $error("self-discharge moved outside brief wake");
  chk_reg_off: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (clk_en_i && wr_mode) ##1 clk_en_i |=>
      regulator_en_o == !$past(reg_req_i.wdata[MODE_REGDIS_BIT], 2))
    else $error("regulator enable does not follow disable bit");
  chk_stat_pin: assert property (
    @(posedge sys_clk_i) disable iff (srst_i)
    (clk_en_i && wr_clr) ##1 clk_en_i |=>
      (stat_o == $past(reg_req_i.wdata[CLR_STAT_BIT], 2)) && (stat_oe_o == !stat_o))
    else $error("status pin does not follow host level");
endmodule

// File: ccc_pkg.sv
// constants, register map and types for the coulomb counter core
// assumes one 25 MHz system clock and a byte register port from the link engine
package ccc_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_PERIOD_NS = 40;
  // duration tick, 0.8789 s per count at the default rate
  localparam longint unsigned DUR_PERIOD_US = 878900;
  localparam int unsigned DUR_TICK_CYCLES = int'(DUR_PERIOD_US * 1000 / CLK_PERIOD_NS);
  // slow rate: 1/256 of normal, 225 s per count
  localparam int unsigned SLOW_DIV = 256;
  localparam int unsigned SLOW_PERIOD_S = 225;
  // self-discharge base tick: one hour split into 256 slices
  localparam longint unsigned SD_HOUR_S = 3600;
  localparam longint unsigned SD_SLICES = 256;
  localparam int unsigned SD_BASE_TICK_CYCLES =
    int'(SD_HOUR_S * 1000000000 / SD_SLICES / CLK_PERIOD_NS);
  // weight sum for one count; weight 4 at the 25 C band gives one per hour
  localparam logic [10:0] SD_COUNT_SUM = 11'h400;
  localparam logic [9:0] KELVIN_AT_0C = 10'h111;
  localparam logic [9:0] SD_BAND_STEP_C = 10'h00A;
  localparam logic [2:0] SD_TOP_BAND = 3'h6;

  // ****************************************
  // register map (byte addresses on the link)
  // ****************************************
  localparam logic [6:0] ADDR_TEMP_LO = 7'h60;
  localparam logic [6:0] ADDR_TEMP_HI = 7'h61;
  localparam logic [6:0] ADDR_CMD = 7'h62;
  localparam logic [6:0] ADDR_CLR = 7'h63;
  localparam logic [6:0] ADDR_MODE = 7'h64;
  localparam logic [6:0] ADDR_CTC_LO = 7'h65;
  localparam logic [6:0] ADDR_CTC_HI = 7'h66;
  localparam logic [6:0] ADDR_DTC_LO = 7'h67;
  localparam logic [6:0] ADDR_DTC_HI = 7'h68;
  localparam logic [6:0] ADDR_SCR_LO = 7'h69;
  localparam logic [6:0] ADDR_SCR_HI = 7'h6A;
  localparam logic [6:0] ADDR_CCR_LO = 7'h6B;
  localparam logic [6:0] ADDR_CCR_HI = 7'h6C;
  localparam logic [6:0] ADDR_DCR_LO = 7'h6D;
  localparam logic [6:0] ADDR_DCR_HI = 7'h6E;

  // clear register bits
  localparam int CLR_DCR_BIT = 0;
  localparam int CLR_CCR_BIT = 1;
  localparam int CLR_SCR_BIT = 2;
  localparam int CLR_DTC_BIT = 3;
  localparam int CLR_CTC_BIT = 4;
  localparam int CLR_STAT_BIT = 5;
  // mode register bits
  localparam int MODE_WAKE_LSB = 1;
  localparam int MODE_DSG_SLOW_BIT = 4;
  localparam int MODE_CHG_SLOW_BIT = 5;
  localparam int MODE_REGDIS_BIT = 6;
  localparam logic [2:0] WAKE_RESET = 3'h7;
  localparam logic STAT_RESET = 1'h1;

  // commands
  localparam logic [7:0] CMD_SLEEP = 8'hF6;
  localparam logic [7:0] CMD_RAM_TO_FLASH = 8'h45;

  // wake thresholds in microvolts for codes 1..7
  localparam logic [7:1][11:0] WAKE_UV = '{
    12'h1F6, 12'h24A, 12'h2BF, 12'h36F, 12'h494, 12'h6DE, 12'hDBC};

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } ccc_reg_req_t;

  typedef enum logic [3:0] {
    ST_RUN = 4'h1,
    ST_DRAIN = 4'h2,
    ST_SLEEP = 4'h4,
    ST_SDWAKE = 4'h8
  } ccc_state_t;

endpackage

// File: ccc_tick_div.sv
// periodic one-cycle tick generator
// assumes the caller holds run_i low to freeze and restart the phase
`timescale 1ns/100ps
module ccc_tick_div #(
  parameter int unsigned PERIOD = 1000
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic ce_i,
  // control
  input wire logic run_i,
  // tick
  output logic tick_o
);
  logic [31:0] cnt;
  wire logic at_end = (cnt == 32'(PERIOD - 1));

  always_ff @(posedge sys_clk_i) begin
    if (srst_i) begin
      cnt <= '0;
      tick_o <= 1'b0;
    end else if (ce_i) begin
      tick_o <= run_i && at_end;
      if (!run_i || at_end) begin
        cnt <= '0;
      end else begin
        cnt <= cnt + 32'h0000_0001;
      end
    end
  end
endmodule

// File: ccc_host_model.sv
// host controller model: register requests and the single-wire line level
// assumes the bench calls its tasks; requests change at the falling edge
`timescale 1ns/100ps
module ccc_host_model import ccc_pkg::*; (
  // clock
  input wire logic sys_clk_i,
  // read data back from the core
  input wire logic [7:0] reg_rdata_i,
  // requests and host line
  output ccc_reg_req_t reg_req_o,
  output logic host_line_o
);
  initial begin
    reg_req_o = '0;
    host_line_o = 1'b1;
  end
  // held over one rising edge; read data lands on that edge
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge sys_clk_i);
    reg_req_o <= '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge sys_clk_i);
    #1;
    q = reg_rdata_i;
  endtask
  task automatic idle;
    @(negedge sys_clk_i);
    reg_req_o <= '0;
  endtask
  task automatic sleep_seq;
    logic [7:0] q;
    xfer(1'b1, ADDR_CMD, CMD_RAM_TO_FLASH, q);
    xfer(1'b1, ADDR_CMD, CMD_SLEEP, q);
    idle();
  endtask
  // any edge of the line wakes the core
  task automatic toggle_line;
    @(negedge sys_clk_i);
    host_line_o <= ~host_line_o;
  endtask
endmodule

// File: ccc_core_bench.sv
// self-checking bench for the coulomb counter core
// assumes short tick parameters so that rates show within a short run
`timescale 1ns/100ps
`define CHK(got, exp) begin checks++; if ((got) !== (exp)) begin bad_count++; \
  $display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module ccc_core_bench;
  import ccc_pkg::*;
  // ****************************************
  // signals and instances
  // ****************************************
  localparam int DURT = 8;
  typedef struct packed {logic ca, da, cp, dp, ic, id;} ccc_row_t;
  ccc_row_t rows [5] = '{6'b101010, 6'b010101, 6'b100100, 6'b111000, 6'b011101};
  logic [8:0] sdt [5] = '{9'h107, 9'h12A, 9'h134, 9'h14D, 9'h161};
  int sdw [5] = '{16384, 4096, 4096, 4096, 4096};
  logic [7:0] sde [5] = '{8'h01, 8'h01, 8'h02, 8'h10, 8'h10};
  logic clk = 0, srst = 1, chg_p = 0, dsg_p = 0, chg_a = 0, dsg_a = 0, ofs = 0, hl, ce = 1;
  logic [11:0] act = 12'h0FFF;
  logic [8:0] temp = 9'h12A;
  ccc_reg_req_t req;
  logic [7:0] rdat, q;
  logic stat, stat_oe, reg_en, slp, fcp;
  logic [15:0] charge_accumulator = 0, discharge_charge_accumulator = 0, v0, v1;
  int bad_count = 0, checks = 0, fc = 0, sw = 0;
  initial forever #20 clk = ~clk;
  always @(posedge clk) if (fcp === 1'b1) fc++;
  ccc_core #(.DUR_TICK(DURT), .SD_TICK(16), .SLOW_RATIO(4)) DUT (
    .sys_clk_i(clk), .srst_i(srst), .clk_en_i(ce), .chg_pulse_i(chg_p),
    .dsg_pulse_i(dsg_p), .chg_active_i(chg_a), .dsg_active_i(dsg_a),
    .offset_pulse_i(ofs), .activity_uv_i(act), .temp_k_i(temp), .host_line_i(hl),
    .reg_req_i(req), .reg_rdata_o(rdat), .stat_o(stat), .stat_oe_o(stat_oe),
    .regulator_en_o(reg_en), .sleep_o(slp), .flash_copy_o(fcp));
  ccc_host_model host (.sys_clk_i(clk), .reg_rdata_i(rdat), .reg_req_o(req),
    .host_line_o(hl));
  task automatic summarize;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic rd16(input logic [6:0] a, output logic [15:0] v);
    host.xfer(1'b0, a, 8'h00, v[7:0]);
    host.xfer(1'b0, a + 7'h01, 8'h00, v[15:8]);
    host.idle();
  endtask
  task automatic wr8(input logic [6:0] a, input logic [7:0] d);
    host.xfer(1'b1, a, d, q);
    host.idle();
  endtask
  // bounded wait; running out ends the run
  task automatic wait_slp(input logic e);
    int n = 0;
    while (slp !== e && n < 20) begin
      @(negedge clk);
      n++;
    end
    if (n == 20) begin
      bad_count++;
      summarize();
    end
  endtask
  task automatic do_reset;
    @(negedge clk);
    srst = 1;
    cyc(3);
    srst = 0;
    `CHK({stat, stat_oe, reg_en, slp}, 4'b1010)
    host.xfer(1'b0, ADDR_MODE, 8'h00, q);
    host.idle();
    `CHK(q, 8'h0E)
    $display("test reset done");
  endtask
  // ****************************************
  // sequence
  // ****************************************
  initial begin
    do_reset();
    foreach (rows[i]) begin
      @(negedge clk);
      {chg_a, dsg_a, chg_p, dsg_p} = {rows[i].ca, rows[i].da, rows[i].cp, rows[i].dp};
      @(negedge clk);
      {chg_a, dsg_a, chg_p, dsg_p} = 4'h0;
      charge_accumulator += 16'(rows[i].ic);
      discharge_charge_accumulator += 16'(rows[i].id);
      rd16(ADDR_CCR_LO, v0);
      `CHK(v0, charge_accumulator)
      rd16(ADDR_DCR_LO, v1);
      `CHK(v1, discharge_charge_accumulator)
    end
    // a strobe under a low clock enable is not taken
    @(negedge clk);
    {ce, chg_a, chg_p} = 3'b011;
    @(negedge clk);
    {ce, chg_a, chg_p} = 3'b100;
    rd16(ADDR_CCR_LO, v0);
    `CHK(v0, charge_accumulator)
    $display("test strobes done");
    // offset count swallows the next strobe only
    @(negedge clk);
    ofs = 1;
    @(negedge clk);
    {ofs, dsg_a, dsg_p} = 3'b011;
    cyc(1);
    dsg_p = 0;
    cyc(1);
    dsg_p = 1;
    cyc(1);
    {dsg_a, dsg_p} = 2'b10;
    discharge_charge_accumulator += 16'h0001;
    rd16(ADDR_DCR_LO, v1);
    `CHK(v1, discharge_charge_accumulator)
    rd16(ADDR_DTC_LO, v0);
    cyc(77);
    rd16(ADDR_DTC_LO, v1);
    dsg_a = 0;
    `CHK(8'(v1[7:0] - v0[7:0]), 8'(80 / DURT))
    host.xfer(1'b1, ADDR_CLR, 8'h3A, q);
    host.xfer(1'b0, ADDR_CLR, 8'h00, q);
    `CHK(q, 8'h3A)
    host.xfer(1'b0, ADDR_CLR, 8'h00, q);
    host.idle();
    `CHK(q, 8'h20)
    charge_accumulator = 0;
    rd16(ADDR_CCR_LO, v0);
    `CHK(v0, charge_accumulator)
    rd16(ADDR_DTC_LO, v1);
    `CHK(v1, 16'h0000)
    $display("test offset, duration and clear done");
    // self-discharge over exact windows, lo byte only
    foreach (sdt[i]) begin
      temp = sdt[i];
      cyc(4);
      rd16(ADDR_SCR_LO, v0);
      cyc(sdw[i] - 3);
      rd16(ADDR_SCR_LO, v1);
      `CHK(8'(v1[7:0] - v0[7:0]), sde[i])
    end
    host.xfer(1'b0, ADDR_TEMP_LO, 8'h00, q);
    `CHK(q, 8'h61)
    host.xfer(1'b0, ADDR_TEMP_HI, 8'h00, q);
    host.idle();
    `CHK(q, 8'h01)
    $display("test self-discharge done");
    temp = 9'h12A;
    wr8(ADDR_MODE, 8'h02);
    rd16(ADDR_SCR_LO, v0);
    fc = 0;
    host.sleep_seq();
    act = 12'h0DBC;
    cyc(20);
    `CHK(fc, 1)
    `CHK(slp, 1'b0)
    act = 12'h0DBB;
    wait_slp(1'b1);
    `CHK(slp, 1'b1)
    {dsg_a, dsg_p} = 2'b11;
    cyc(1);
    dsg_p = 0;
    // one awake cycle per self-discharge tick, none otherwise
    sw = 0;
    repeat (4096) begin
      @(negedge clk);
      if (slp !== 1'b1) sw++;
    end
    `CHK(sw, 4096 / 16)
    `CHK(reg_en, 1'b1)
    dsg_a = 0;
    host.toggle_line();
    wait_slp(1'b0);
    cyc(4);
    `CHK(slp, 1'b0)
    rd16(ADDR_SCR_LO, v1);
    `CHK((v1 !== v0), 1'b1)
    rd16(ADDR_DCR_LO, v1);
    `CHK(v1, discharge_charge_accumulator)
    rd16(ADDR_DTC_LO, v1);
    `CHK(v1, 16'h0000)
    $display("test sleep done");
    wr8(ADDR_CLR, 8'h00);
    cyc(2);
    `CHK({stat, stat_oe}, 2'b01)
    wr8(ADDR_CLR, 8'h20);
    cyc(2);
    `CHK({stat, stat_oe}, 2'b10)
    wr8(ADDR_MODE, 8'h70);
    cyc(2);
    `CHK(reg_en, 1'b0)
    host.xfer(1'b0, ADDR_MODE, 8'h00, q);
    `CHK(q, 8'h40)
    host.xfer(1'b0, 7'h70, 8'h00, q);
    `CHK(q, 8'h00)
    host.idle();
    // wake code 0: no threshold, sleep follows the command at once
    host.sleep_seq();
    wait_slp(1'b1);
    `CHK(slp, 1'b1)
    `CHK(reg_en, 1'b0)
    host.toggle_line();
    wait_slp(1'b0);
    cyc(4);
    `CHK(slp, 1'b0)
    $display("test status and mode done");
    do_reset();
    summarize();
  end
endmodule
